/* core/input_fifo_level_control.sv */
// Pointer spacing control and depth readback for the input data buffer
`include "fifo_level_map.svh"

module input_fifo_level_control
(
    input  wire logic       CLK,
    input  wire logic       RST,
    input  wire logic       DATA_CLK,
    input  wire logic [7:0] REG_ADDR,
    input  wire logic       REG_WR,
    input  wire logic [7:0] REG_WDATA,
    input  wire logic       REG_RD,
    input  wire logic [1:0] INTERP_SEL,
    input  wire logic       FRAME_VALID,
    input  wire logic [1:0] FRAME_MODE,
    output logic      [7:0] REG_RDATA,
    output logic      [2:0] WRITE_PTR,
    output logic      [2:0] READ_PTR,
    output logic            RESET_BUSY
);

    fifo_level_pkg::align_state_e state_reg;

    logic [2:0] int_req_reg;
    logic [2:0] frac_req_reg;
    logic [2:0] int_rb_reg;
    logic [2:0] frac_rb_reg;
    logic       spi_req_reg;
    logic       spi_ack_reg;
    logic       spi_pend_reg;
    logic       req_prev_reg;
    logic [2:0] wptr_reg;
    logic [2:0] rptr_reg;
    logic [2:0] phase_reg;
    logic       data_rise;
    logic [2:0] ratio_m1;
    logic [2:0] frac_lim;
    logic       wr_depth;
    logic       wr_ctrl;
    logic       start_spi;
    logic       start_frame;
    logic       settle_done;

    link_edge_sync u_sync
    (
        .clk     (CLK),
        .rst     (RST),
        .d_async (DATA_CLK),
        .rise    (data_rise)
    );

    always_comb
    begin
        case (INTERP_SEL)
            `INTERP_4X: ratio_m1 = `RATIO_M1_4X;
            `INTERP_8X: ratio_m1 = `RATIO_M1_8X;
            default:    ratio_m1 = `RATIO_M1_2X;
        endcase
    end

    // Out-of-range fraction is clamped so the read phase never overruns
    assign frac_lim    = (frac_req_reg > ratio_m1) ? ratio_m1 : frac_req_reg;
    assign wr_depth    = REG_WR && REG_ADDR == `DEPTH_REQ_ADDR;
    assign wr_ctrl     = REG_WR && REG_ADDR == `RST_CTRL_ADDR;
    assign start_spi   = spi_req_reg && !req_prev_reg;
    assign start_frame = FRAME_VALID &&
                         (FRAME_MODE == `FRAME_FIFO_ONLY || FRAME_MODE == `FRAME_FIFO_OSC);
    assign settle_done = state_reg == fifo_level_pkg::ST_SETTLE && data_rise;

    assign WRITE_PTR = wptr_reg;
    assign READ_PTR  = rptr_reg;

    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            int_req_reg  <= `INT_REQ_RESET;
            frac_req_reg <= `FRAC_REQ_RESET;
        end
        else if (wr_depth)
        begin
            int_req_reg  <= REG_WDATA[`INT_MSB:`INT_LSB];
            frac_req_reg <= REG_WDATA[`FRAC_MSB:`FRAC_LSB];
        end
    end

    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            spi_req_reg  <= 1'b0;
            req_prev_reg <= 1'b0;
        end
        else
        begin
            req_prev_reg <= spi_req_reg;
            if (wr_ctrl)
                spi_req_reg <= REG_WDATA[`REQ_BIT];
        end
    end

    // Acknowledge set wins over the clear from a dropped request
    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            spi_pend_reg <= 1'b0;
            spi_ack_reg  <= 1'b0;
        end
        else
        begin
            if (settle_done && spi_pend_reg)
            begin
                spi_ack_reg  <= 1'b1;
                spi_pend_reg <= 1'b0;
            end
            else
            begin
                if (start_spi)
                    spi_pend_reg <= 1'b1;
                if (!spi_req_reg)
                    spi_ack_reg <= 1'b0;
            end
        end
    end

    // Reset aligned to a write edge so spacing is measured from a known point
    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            state_reg  <= fifo_level_pkg::ST_IDLE;
            RESET_BUSY <= 1'b0;
        end
        else
        begin
            case (state_reg)
                fifo_level_pkg::ST_IDLE:
                begin
                    if (start_spi || start_frame)
                    begin
                        state_reg  <= fifo_level_pkg::ST_ARMED;
                        RESET_BUSY <= 1'b1;
                    end
                end
                fifo_level_pkg::ST_ARMED:
                begin
                    if (data_rise)
                        state_reg <= fifo_level_pkg::ST_SETTLE;
                end
                fifo_level_pkg::ST_SETTLE:
                begin
                    if (data_rise)
                    begin
                        state_reg  <= fifo_level_pkg::ST_IDLE;
                        RESET_BUSY <= 1'b0;
                    end
                end
                default:
                begin
                    state_reg  <= fifo_level_pkg::ST_IDLE;
                    RESET_BUSY <= 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge CLK)
    begin
        if (RST)
            wptr_reg <= 3'h0;
        else if (data_rise)
            wptr_reg <= 3'(wptr_reg + 3'h1);
    end

    // Phase counts converter cycles down within one input sample
    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            rptr_reg  <= 3'h0;
            phase_reg <= 3'h0;
        end
        else if (state_reg == fifo_level_pkg::ST_ARMED && data_rise)
        begin
            rptr_reg  <= 3'(wptr_reg + 3'h1 - int_req_reg);
            phase_reg <= frac_lim;
        end
        else if (phase_reg == 3'h0)
        begin
            rptr_reg  <= 3'(rptr_reg + 3'h1);
            phase_reg <= ratio_m1;
        end
        else
        begin
            phase_reg <= 3'(phase_reg - 3'h1);
        end
    end

    // One sample after alignment; edge jitter keeps error within two cycles
    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            int_rb_reg  <= 3'h0;
            frac_rb_reg <= 3'h0;
        end
        else if (settle_done)
        begin
            int_rb_reg  <= 3'(wptr_reg + 3'h1 - rptr_reg);
            frac_rb_reg <= phase_reg;
        end
    end

    always_ff @(posedge CLK)
    begin
        if (RST)
            REG_RDATA <= 8'h00;
        else if (REG_RD)
        begin
            case (REG_ADDR)
                `DEPTH_REQ_ADDR:  REG_RDATA <= {1'b0, int_req_reg, 1'b0, frac_req_reg};
                `DEPTH_STAT_ADDR: REG_RDATA <= {1'b0, int_rb_reg, 1'b0, frac_rb_reg};
                `RST_CTRL_ADDR:   REG_RDATA <= {6'h00, spi_ack_reg, spi_req_reg};
                default:          REG_RDATA <= 8'h00;
            endcase
        end
    end

    property p_req_reset;
        @(posedge CLK) $fell(RST) |-> int_req_reg == `INT_REQ_RESET && frac_req_reg == `FRAC_REQ_RESET;
    endproperty
    a_req_reset: assert property (p_req_reset) else $error("depth request not 4.0 after reset");

    property p_stat_reset;
        @(posedge CLK) $fell(RST) |-> int_rb_reg == 3'h0 && frac_rb_reg == 3'h0 && !spi_ack_reg && !spi_req_reg;
    endproperty
    a_stat_reset: assert property (p_stat_reset) else $error("status or control not zero after reset");

    property p_spi_start;
        @(posedge CLK) disable iff (RST)
            wr_ctrl && REG_WDATA[`REQ_BIT] && !spi_req_reg && state_reg == fifo_level_pkg::ST_IDLE
            |=> ##1 state_reg == fifo_level_pkg::ST_ARMED && RESET_BUSY;
    endproperty
    a_spi_start: assert property (p_spi_start) else $error("serial request did not start reset");

    property p_frame_start;
        @(posedge CLK) disable iff (RST)
            start_frame && state_reg == fifo_level_pkg::ST_IDLE |=> state_reg == fifo_level_pkg::ST_ARMED;
    endproperty
    a_frame_start: assert property (p_frame_start) else $error("frame pulse did not start reset");

    property p_align;
        @(posedge CLK) disable iff (RST)
            state_reg == fifo_level_pkg::ST_ARMED && data_rise
            |=> rptr_reg == 3'($past(wptr_reg) + 3'h1 - $past(int_req_reg)) && wptr_reg == 3'($past(wptr_reg) + 3'h1);
    endproperty
    a_align: assert property (p_align) else $error("read pointer not placed at requested spacing");

    property p_stat_update;
        @(posedge CLK) disable iff (RST)
            (int_rb_reg != $past(int_rb_reg) || frac_rb_reg != $past(frac_rb_reg)) |-> $past(settle_done);
    endproperty
    a_stat_update: assert property (p_stat_update) else $error("depth status changed outside settle");

    property p_ack_set;
        @(posedge CLK) disable iff (RST)
            $rose(spi_ack_reg) |-> $past(spi_pend_reg) && $past(state_reg) == fifo_level_pkg::ST_SETTLE && !RESET_BUSY;
    endproperty
    a_ack_set: assert property (p_ack_set) else $error("acknowledge without completed serial reset");

    property p_ack_clear;
        @(posedge CLK) disable iff (RST)
            !spi_req_reg && !(settle_done && spi_pend_reg) |=> !spi_ack_reg;
    endproperty
    a_ack_clear: assert property (p_ack_clear) else $error("acknowledge held after request cleared");

    property p_phase_bound;
        @(posedge CLK) disable iff (RST)
            $stable(INTERP_SEL) && $past(phase_reg) <= ratio_m1 |-> phase_reg <= ratio_m1;
    endproperty
    a_phase_bound: assert property (p_phase_bound) else $error("read phase beyond interpolation ratio");

endmodule : input_fifo_level_control

/* core/fifo_level_map.svh */
// Register map, field positions and codes for the input buffer level control
// Overview of operation
// - Integral depth request, bits 6..4, sets spacing in input samples, codes 0..7.
// - After reset integral request is 4 and fractional request is 0.
// - Fractional depth request, bits 2..0, adds spacing in converter clock cycles.
// - Achieved integral spacing reads back in bits 6..4 of depth status.
// - Reported total depth stays within two converter cycles of the request for fractions up to the ratio less one.
// - Achieved fractional spacing reads back in bits 2..0 of depth status.
// - Setting control bit 0 from the serial port starts a buffer pointer reset.
// - Control bit 1 acknowledges a buffer reset started from the serial port.
// - Depth status and control registers reset to zero.
// - Interpolation select 00, 10, 11 gives ratio 2, 4, 8.
// - Valid frame pulse resets the buffer when frame target is 00 or 10.
`ifndef FIFO_LEVEL_MAP_SVH
`define FIFO_LEVEL_MAP_SVH

`define DEPTH_REQ_ADDR   8'h23
`define DEPTH_STAT_ADDR  8'h24
`define RST_CTRL_ADDR    8'h25

`define DEPTH_REQ_RESET  8'h40
`define INT_REQ_RESET    3'h4
`define FRAC_REQ_RESET   3'h0

`define INT_MSB          6
`define INT_LSB          4
`define FRAC_MSB         2
`define FRAC_LSB         0
`define REQ_BIT          0
`define ACK_BIT          1

`define INTERP_2X        2'h0
`define INTERP_4X        2'h2
`define INTERP_8X        2'h3
`define RATIO_M1_2X      3'h1
`define RATIO_M1_4X      3'h3
`define RATIO_M1_8X      3'h7

`define FRAME_FIFO_ONLY  2'h0
`define FRAME_FIFO_OSC   2'h2

`endif

/* core/fifo_level_pkg.sv */
// Types shared by the input buffer level control
package fifo_level_pkg;

    typedef enum logic [1:0]
    {
        ST_IDLE   = 2'h0,
        ST_ARMED  = 2'h1,
        ST_SETTLE = 2'h3
    } align_state_e;

endpackage : fifo_level_pkg

/* core/link_edge_sync.sv */
// Three-stage synchroniser with rising edge detect for the input data clock
module link_edge_sync
(
    input  wire logic clk,
    input  wire logic rst,
    input  wire logic d_async,
    output logic      rise
);

    logic s1_reg;
    logic s2_reg;
    logic s3_reg;
    logic level_reg;

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            s1_reg <= 1'b0;
            s2_reg <= 1'b0;
            s3_reg <= 1'b0;
        end
        else
        begin
            s1_reg <= d_async;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
        end
    end

    // Change accepted only once second and third stage agree
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            level_reg <= 1'b0;
            rise      <= 1'b0;
        end
        else
        begin
            rise <= 1'b0;
            if (s2_reg == s3_reg && s3_reg != level_reg)
            begin
                level_reg <= s3_reg;
                rise      <= s3_reg;
            end
        end
    end

endmodule : link_edge_sync

/* test/data_clock_source.sv */
// Input data clock source model standing at the far side of the buffer
module data_clock_source
(
    input  wire logic run,
    output logic      data_clk
);
    timeunit 1ns;
    timeprecision 100ps;

    // Held low while stopped so no stray edge reaches the synchroniser
    initial data_clk = 1'b0;
    always #40 data_clk = run ? ~data_clk : 1'b0;
endmodule : data_clock_source

/* test/input_fifo_level_control_tb.sv */
// Self-checking bench for the input buffer level control
`include "fifo_level_map.svh"

module input_fifo_level_control_tb;
    timeunit 1ns;
    timeprecision 100ps;

    logic       clk         = 1'b0;
    logic       rst         = 1'b1;
    logic       run         = 1'b0;
    logic       reg_wr      = 1'b0;
    logic       reg_rd      = 1'b0;
    logic       frame_valid = 1'b0;
    logic [7:0] reg_addr    = 8'h00;
    logic [7:0] reg_wdata   = 8'h00;
    logic [1:0] interp_sel  = 2'h3;
    logic [1:0] frame_mode  = 2'h3;
    logic       data_clk;
    logic       reset_busy;
    logic [7:0] reg_rdata;
    logic [2:0] write_ptr;
    logic [2:0] read_ptr;
    logic [7:0] rd_val;
    logic [2:0] ival;
    logic [2:0] fval;
    int         n_errors;
    int         samples_checked;
    int         cycles;
    int         diff;
    // Register model; a negative entry marks a value not predicted exactly
    int         mdl [int];
    logic [1:0] sel_tab [3] = '{`INTERP_2X, `INTERP_4X, `INTERP_8X};
    logic [2:0] lim_tab [3] = '{`RATIO_M1_2X, `RATIO_M1_4X, `RATIO_M1_8X};

    always #5 clk = ~clk;

    data_clock_source u_data_clock_source
    (
        .run      (run),
        .data_clk (data_clk)
    );

    input_fifo_level_control u_input_fifo_level_control
    (
        .CLK         (clk),
        .RST         (rst),
        .DATA_CLK    (data_clk),
        .REG_ADDR    (reg_addr),
        .REG_WR      (reg_wr),
        .REG_WDATA   (reg_wdata),
        .REG_RD      (reg_rd),
        .INTERP_SEL  (interp_sel),
        .FRAME_VALID (frame_valid),
        .FRAME_MODE  (frame_mode),
        .REG_RDATA   (reg_rdata),
        .WRITE_PTR   (write_ptr),
        .READ_PTR    (read_ptr),
        .RESET_BUSY  (reset_busy)
    );

    task automatic conclude();
        if (n_errors == 0 && samples_checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : conclude

    task automatic check8(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            n_errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check8

    task automatic check1(input logic got, input logic exp);
        samples_checked++;
        if (got !== exp)
        begin
            n_errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check1

    task automatic put(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr    <= 1'b0;
        if (a == `DEPTH_REQ_ADDR)
            mdl[a] = d & 8'h77;
        if (a == `RST_CTRL_ADDR)
            mdl[a] = d[0] ? (mdl[a] | 1) : 0;
    endtask : put

    task automatic get(input logic [7:0] a);
        @(posedge clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk);
        reg_rd   <= 1'b0;
        @(posedge clk);
        #1;
        rd_val = reg_rdata;
        if (!mdl.exists(a))
            check8(rd_val, 8'h00);
        else if (mdl[a] >= 0)
            check8(rd_val, 8'(mdl[a]));
    endtask : get

    task automatic wait_busy(input logic lvl, input int lim);
        int k;
        k = 0;
        // Step off the launching edge before looking at the busy flag
        #1;
        while (reset_busy !== lvl && k < lim)
        begin
            @(posedge clk);
            #1;
            k++;
        end
        check1(reset_busy, lvl);
    endtask : wait_busy

    // At 8x one input sample is eight converter cycles, so spacing equals the integral request
    task automatic check_ptrs();
        if (interp_sel == `INTERP_8X)
            check8({5'h00, 3'(write_ptr - read_ptr)}, {5'h00, ival});
    endtask : check_ptrs

    task automatic serial_reset();
        put(`RST_CTRL_ADDR, 8'h01);
        wait_busy(1'b1, 8);
        wait_busy(1'b0, 60);
        check_ptrs();
        mdl[`RST_CTRL_ADDR] = 8'h03;
        get(`RST_CTRL_ADDR);
        put(`RST_CTRL_ADDR, 8'h00);
        get(`RST_CTRL_ADDR);
    endtask : serial_reset

    // Guards against a hang in any bounded wait above
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 6000)
        begin
            n_errors++;
            conclude();
        end
    end

    initial
    begin
        void'($urandom(7369));
        mdl[`DEPTH_REQ_ADDR]  = `DEPTH_REQ_RESET;
        mdl[`DEPTH_STAT_ADDR] = 0;
        mdl[`RST_CTRL_ADDR]   = 0;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        run <= 1'b1;
        get(`DEPTH_REQ_ADDR);
        get(`DEPTH_STAT_ADDR);
        get(`RST_CTRL_ADDR);
        get(8'h30);
        put(`DEPTH_STAT_ADDR, 8'hFF);
        get(`DEPTH_STAT_ADDR);
        put(`RST_CTRL_ADDR, 8'h02);
        get(`RST_CTRL_ADDR);
        mdl[`DEPTH_STAT_ADDR] = -1;
        for (int k = 0; k < 9; k++)
        begin
            ival = 3'($urandom_range(7, 0));
            fval = 3'($urandom_range(lim_tab[k % 3], 0));
            if (k == 5)
                {ival, fval} = 6'h3F;
            @(posedge clk);
            interp_sel <= sel_tab[k % 3];
            put(`DEPTH_REQ_ADDR, {1'b1, ival, 1'b1, fval});
            get(`DEPTH_REQ_ADDR);
            serial_reset();
            if (k % 3 == 2)
            begin
                get(`DEPTH_STAT_ADDR);
                check8(rd_val & 8'h88, 8'h00);
                diff = (int'(rd_val[6:4]) * 8 + int'(rd_val[2:0]) - int'(ival) * 8 - int'(fval) + 64) % 64;
                check1(diff <= 2 || diff >= 62, 1'b1);
            end
        end
        for (int f = 0; f < 4; f++)
        begin
            @(posedge clk);
            frame_mode  <= 2'(f);
            frame_valid <= 1'b1;
            @(posedge clk);
            frame_valid <= 1'b0;
            if (f == 0 || f == 2)
            begin
                wait_busy(1'b1, 4);
                wait_busy(1'b0, 60);
                check_ptrs();
            end
            else
            begin
                repeat (8) @(posedge clk);
                #1;
                check1(reset_busy, 1'b0);
            end
            get(`RST_CTRL_ADDR);
        end
        conclude();
    end
endmodule : input_fifo_level_control_tb
